/* rcp_core.v */
// Reset cause recorder, power mode control and peripheral power gating, with APB access.
// Assumes rstn is the power-on reset; other resets arrive as event inputs and leave it high.
//
// What this block does
// RQ1 - Low reset pin in stop gives system reset
// RQ2 - Filter ignores reset pin lows under 12 ns
// RQ3 - Nine low bit times on debug pin resets
// RQ4 - Framing error or collision also raises debug reset
// RQ5 - Stop-mode debug reset resets all but debugger, sets power-on flag
// RQ6 - Status is read-only; reads clear upper four flags
// RQ7 - Status shares FF0 with write-only watchdog control
// RQ8 - Each reset source sets its own single flag; here brownout and debugger resets all set the power-on flag
// RQ9 - GPIO recovery sets stop; watchdog recovery adds watchdog
// RQ10 - Watchdog time-out or recovery clears power-on flag
// RQ11 - Stop flag cleared by power-on or run-mode watchdog
// RQ12 - Watchdog flag set on time-out, cleared by pin recovery
// RQ13 - External flag set by pin reset, cleared by pin recovery
// RQ14 - Software reads status before clearing watchdog interrupt
// RQ15 - Stop and halt instructions enter their modes
// RQ16 - Stop halts oscillators, clock, CPU, counter; crystal pins to GPIO
// RQ17 - Stop keeps watchdog when enabled, brownout per option
// RQ18 - Halt keeps oscillator, clock, peripherals; CPU stops
// RQ19 - Halt exits on interrupt, watchdog, power-on, brownout, pin
// RQ20 - Gating register reset only by power-on
// RQ21 - Gating bit 4 disables brownout unless always-on
// RQ22 - Gating bit 1 disables comparator
// RQ23 - Clear-on-read acts after the read data returns
`include "rcp_map.vh"

module rcp_core (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire reset_pin_n,
  input wire debug_pin,
  input wire dbg_frame_stop_valid,
  input wire dbg_frame_stop_bit,
  input wire dbg_tx_active,
  input wire dbg_tx_bit,
  input wire debugger_cmd_reset,
  input wire brownout_reset,
  input wire wdog_timeout,
  input wire wdog_reset_mode,
  input wire wdog_enable,
  input wire gpio_recover,
  input wire irq_pending,
  input wire stop_instr,
  input wire halt_instr,
  input wire brownout_always_on_option,
  input wire brownout_stop_option,
  output reg [7:0] wdog_ctl_data,
  output reg wdog_ctl_we,
  output reg sys_reset_r,
  output reg dbg_keep_r,
  output reg stop_mode_r,
  output reg halt_mode_r,
  output reg osc_run_r,
  output reg sys_clk_en_r,
  output reg cpu_run_r,
  output reg xtal_pins_gpio_r,
  output reg wdog_run_r,
  output reg periph_run_r,
  output reg brownout_detector_disable,
  output reg comparator_disable
);

  // ************************************************************
  // State
  // ************************************************************
  localparam ST_RUN = 3'b001;
  localparam ST_HALT = 3'b010;
  localparam ST_STOP = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] flags_r;
  reg [3:0] flags_nxt;
  reg [7:0] peripheral_power_gating;
  reg [7:0] prdata_nxt;
  wire pin_low;
  wire dbg_reset;
  wire in_stop;
  wire rd_status;
  wire wr_gate;
  wire apb_acc;
  wire addr_ok;
  wire stop_rst;
  wire pin_rst;
  wire any_sys_rst;

  rcp_glitch_filter u_filter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin_n(reset_pin_n),
    .low_seen_r(pin_low)
  );

  rcp_debug_watch u_dbg (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .debug_pin(debug_pin),
    .frame_stop_valid(dbg_frame_stop_valid),
    .frame_stop_bit(dbg_frame_stop_bit),
    .tx_active(dbg_tx_active),
    .tx_bit(dbg_tx_bit),
    .dbg_reset_r(dbg_reset)
  );

  assign in_stop = (state_r == ST_STOP);
  assign apb_acc = psel && penable;
  assign addr_ok = (paddr[11:0] == `RCP_STATUS_ADDR) || (paddr[11:0] == `RCP_PGATE_ADDR);
  // Clear acts at the handover edge, after prdata has been captured
  assign rd_status = apb_acc && pready && !pwrite && paddr[11:0] == `RCP_STATUS_ADDR;
  assign wr_gate = apb_acc && pwrite && paddr[11:0] == `RCP_PGATE_ADDR;
  assign pin_rst = pin_low; // [RQ2]
  // Stop-mode debug reset is the only debug reset handled here
  assign stop_rst = in_stop && dbg_reset; // [RQ5]
  assign any_sys_rst = pin_rst | stop_rst | debugger_cmd_reset | brownout_reset
                       | (wdog_timeout & wdog_reset_mode & ~in_stop);

  // ************************************************************
  // Reset cause flags: POR, STOP, WDOG, EXTERNAL_RESET_FLAG
  // ************************************************************
  always @* begin
    flags_nxt = flags_r;
    // Clear first so any event in the same cycle wins
    if (rd_status) begin
      // Only what the read returned is cleared, so a flag set in between survives
      flags_nxt = flags_r & ~prdata[7:4]; // [RQ6] [RQ23]
    end
    if (pin_rst) begin
      flags_nxt = 4'b0001; // [RQ1] [RQ8] [RQ13]
    end else if (stop_rst || debugger_cmd_reset || brownout_reset) begin
      flags_nxt = 4'b1000; // [RQ5] [RQ8]
    end else if (in_stop && wdog_timeout) begin
      flags_nxt = 4'b0110; // [RQ9] [RQ10]
    end else if (in_stop && gpio_recover) begin
      flags_nxt = 4'b0100; // [RQ9] [RQ12] [RQ13]
    end else if (wdog_timeout) begin
      flags_nxt = 4'b0010; // [RQ8] [RQ10] [RQ11] [RQ12]
    end
  end

  // ************************************************************
  // Power mode state machine
  // ************************************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_instr) begin
          state_nxt = ST_STOP; // [RQ15]
        end else if (halt_instr) begin
          state_nxt = ST_HALT; // [RQ15]
        end
      end
      ST_HALT: begin
        if (irq_pending || wdog_timeout || any_sys_rst) begin
          state_nxt = ST_RUN; // [RQ19]
        end
      end
      ST_STOP: begin
        if (wdog_timeout || gpio_recover || pin_rst || stop_rst) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @* begin
    prdata_nxt = 8'h00;
    if (paddr[11:0] == `RCP_STATUS_ADDR) begin
      prdata_nxt = {flags_r, 4'h0}; // [RQ7]
    end else if (paddr[11:0] == `RCP_PGATE_ADDR) begin
      prdata_nxt = peripheral_power_gating;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // Power-on reset: only the power-on flag stands afterwards
      flags_r <= 4'b1000; // [RQ8] [RQ11] [RQ12] [RQ13]
      peripheral_power_gating <= `RCP_PG_RESET; // [RQ20]
      state_r <= ST_RUN;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      wdog_ctl_data <= 8'h00;
      wdog_ctl_we <= 1'b0;
      sys_reset_r <= 1'b0;
      dbg_keep_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      state_r <= any_sys_rst ? ST_RUN : state_nxt;
      // Other resets leave the gating register untouched
      if (wr_gate) begin
        peripheral_power_gating <= pwdata[7:0] & `RCP_PG_WMASK; // [RQ20]
      end
      // One-cycle wait state: pready rises in the second access cycle
      pready <= apb_acc && !pready;
      pslverr <= apb_acc && !pready && !addr_ok;
      if (apb_acc && !pready && !pwrite) begin
        prdata <= {24'h000000, prdata_nxt};
      end
      // Status address writes go to the watchdog control
      wdog_ctl_we <= apb_acc && !pready && pwrite && paddr[11:0] == `RCP_STATUS_ADDR; // [RQ7]
      if (apb_acc && pwrite) begin
        wdog_ctl_data <= pwdata[7:0];
      end
      sys_reset_r <= any_sys_rst; // [RQ1] [RQ5]
      dbg_keep_r <= stop_rst; // [RQ5]
    end
  end

  // ************************************************************
  // Clock and peripheral enables per mode, watchdog enable, options and gating bits
  // ************************************************************
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stop_mode_r <= 1'b0;
      halt_mode_r <= 1'b0;
      osc_run_r <= 1'b1;
      sys_clk_en_r <= 1'b1;
      cpu_run_r <= 1'b1;
      xtal_pins_gpio_r <= 1'b0;
      wdog_run_r <= 1'b0;
      periph_run_r <= 1'b1;
      brownout_detector_disable <= 1'b0;
      comparator_disable <= 1'b0;
    end else begin
      stop_mode_r <= (state_nxt == ST_STOP);
      halt_mode_r <= (state_nxt == ST_HALT);
      osc_run_r <= (state_nxt != ST_STOP); // [RQ16] [RQ18]
      sys_clk_en_r <= (state_nxt != ST_STOP); // [RQ16] [RQ18]
      cpu_run_r <= (state_nxt == ST_RUN); // [RQ16] [RQ18]
      xtal_pins_gpio_r <= (state_nxt == ST_STOP); // [RQ16]
      wdog_run_r <= wdog_enable; // [RQ17] [RQ18]
      periph_run_r <= (state_nxt != ST_STOP); // [RQ17] [RQ18]
      if (brownout_always_on_option) begin
        brownout_detector_disable <= (state_nxt == ST_STOP) && !brownout_stop_option; // [RQ17]
      end else begin
        brownout_detector_disable <= (state_nxt == ST_STOP)
                                     || peripheral_power_gating[`RCP_PG_BROWNOUT]; // [RQ21]
      end
      comparator_disable <= peripheral_power_gating[`RCP_PG_COMP]; // [RQ22]
    end
  end

endmodule // rcp_core

/* rcp_core_bench.sv */
// Self-checking bench for the reset cause and power mode block.
// Assumes the checker is bound in; reset cause events are driven as pulses.
module rcp_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r;
  logic reset_pin_n, debug_pin, fsv, fsb, txa, txb, cmd_rst, wdt_to, gpio_rec, irq, stp, hlt;
  logic sysr, stop_m, halt_m, comp_dis, e, dkeep, bod;
  logic [7:0] wc_data;
  logic [7:0] exp_st, g, exp_tab [0:8];
  integer error_cnt, check_count, seed, k;
  rcp_core DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .debug_pin(debug_pin),
    .dbg_frame_stop_valid(fsv), .dbg_frame_stop_bit(fsb), .dbg_tx_active(txa),
    .dbg_tx_bit(txb), .debugger_cmd_reset(cmd_rst), .brownout_reset(1'b0),
    .wdog_timeout(wdt_to), .wdog_reset_mode(1'b0), .wdog_enable(1'b1),
    .gpio_recover(gpio_rec), .irq_pending(irq), .stop_instr(stp), .halt_instr(hlt),
    .brownout_always_on_option(1'b0), .brownout_stop_option(1'b0), .wdog_ctl_data(wc_data),
    .wdog_ctl_we(), .sys_reset_r(sysr), .dbg_keep_r(dkeep), .stop_mode_r(stop_m),
    .halt_mode_r(halt_m), .osc_run_r(), .sys_clk_en_r(), .cpu_run_r(),
    .xtal_pins_gpio_r(), .wdog_run_r(), .periph_run_r(), .brownout_detector_disable(bod),
    .comparator_disable(comp_dis));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Errors %0d of %0d checks", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One APB transfer; the bench holds the request until pready is seen
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {20'h0, a}; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 20) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  task rd_st;
    apb(12'hff0, 0, 0);
    cmp(r, {24'h0, exp_st});
    exp_st = 8'h00;
  endtask
  task wait_rst;
    integer n;
    for (n = 0; n < 300 && sysr !== 1'b1; n++) @(posedge clk_sys);
    if (n >= 300) begin
      error_cnt++;
      give_verdict;
    end
  endtask
  initial begin
    error_cnt = 0; check_count = 0; seed = 32'h8b95;
    exp_tab = '{8'h40, 8'h60, 8'h20, 8'h10, 8'h80, 8'h80, 8'h80, 8'h80, 8'h40};
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    reset_pin_n = 1; debug_pin = 1; fsv = 0; fsb = 1; txa = 0; txb = 0;
    cmd_rst = 0; wdt_to = 0; gpio_rec = 0; irq = 0; stp = 0; hlt = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1;
    exp_st = 8'h80;
    rd_st;
    rd_st;
    apb(12'hf80, 0, 0);
    cmp(r, 32'h88);
    k = $random(seed);
    g = k[7:0] & 8'h12;
    apb(12'hf80, 1, k);
    apb(12'hf80, 0, 0);
    cmp(r, {24'h0, g});
    cmp(comp_dis, g[1]);
    cmp(bod, g[4]);
    apb(12'hff0, 1, 32'h000000ff);
    cmp(wc_data, 32'hff);
    rd_st;
    apb(12'h100, 0, 0);
    cmp({31'h0, e}, 32'h1);
    cmp(r, 32'h0);
    for (k = 0; k < 9; k++) begin
      if (k != 2 && k != 7) begin
        @(posedge clk_sys) stp <= 1;
        @(posedge clk_sys) stp <= 0;
        repeat (2) @(posedge clk_sys);
        cmp(stop_m, 1);
        cmp(bod, 1);
      end
      // A one-cycle low on the pin must not count as a pin reset
      if (k == 8) begin
        @(posedge clk_sys) reset_pin_n <= 0;
        @(posedge clk_sys) reset_pin_n <= 1;
        repeat (6) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      case (k)
        0, 8: gpio_rec <= 1;
        1, 2: wdt_to <= 1;
        3: reset_pin_n <= 0;
        4: debug_pin <= 0;
        5: begin fsv <= 1; fsb <= 0; end
        6: begin txa <= 1; txb <= 1; debug_pin <= 0; end
        default: cmd_rst <= 1;
      endcase
      @(posedge clk_sys);
      gpio_rec <= 0; wdt_to <= 0; fsv <= 0; fsb <= 1; txa <= 0; txb <= 0; cmd_rst <= 0;
      if (k == 6) debug_pin <= 1;
      if (k >= 3 && k <= 7) begin
        wait_rst;
        cmp(dkeep, k >= 4 && k <= 6);
      end
      reset_pin_n <= 1; debug_pin <= 1;
      repeat (4) @(posedge clk_sys);
      exp_st = exp_tab[k];
      rd_st;
    end
    apb(12'hf80, 0, 0);
    cmp(r, {24'h0, g});
    @(posedge clk_sys) hlt <= 1;
    @(posedge clk_sys) hlt <= 0;
    repeat (2) @(posedge clk_sys);
    cmp(halt_m, 1);
    @(posedge clk_sys) irq <= 1;
    @(posedge clk_sys) irq <= 0;
    repeat (2) @(posedge clk_sys);
    cmp(halt_m, 0);
    give_verdict;
  end
endmodule // rcp_core_bench

/* rcp_core_checker.sv */
// Concurrent checks on the ports of the reset cause and power mode block.
// Assumes one clock domain and an APB master that keeps the bus legal.
module rcp_core_checker (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire reset_pin_n,
  input wire wdog_enable,
  input wire wdog_ctl_we,
  input wire sys_reset_r,
  input wire stop_mode_r,
  input wire halt_mode_r,
  input wire osc_run_r,
  input wire sys_clk_en_r,
  input wire cpu_run_r,
  input wire xtal_pins_gpio_r,
  input wire wdog_run_r,
  input wire periph_run_r,
  input wire comparator_disable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire [11:0] a = paddr[11:0];
  wire mapped = (a == 12'hff0) || (a == 12'hf80);
  wire rd_done = pready && !pwrite;
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_time: assert property (psel && $rose(penable) |-> ##1 pready)
    else $error("access phase not two cycles");
  chk_slverr_map: assert property (pready |-> (pslverr == !mapped))
    else $error("pslverr does not follow the address map");
  chk_read_upper: assert property (rd_done |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  chk_wdog_write: assert property (psel && $rose(penable) && pwrite && a == 12'hff0
    |-> ##[0:2] wdog_ctl_we)
    else $error("write to shared address missed watchdog control");
  chk_comp_gate: assert property (rd_done && a == 12'hf80
    |-> prdata[1] == comparator_disable)
    else $error("comparator disable differs from gating bit");
  chk_stop_clocks: assert property (stop_mode_r && $past(stop_mode_r)
    |-> !osc_run_r && !sys_clk_en_r && !cpu_run_r && xtal_pins_gpio_r && !periph_run_r)
    else $error("stop mode left something running");
  chk_stop_wdog: assert property (stop_mode_r && $past(stop_mode_r) && wdog_enable
    && $past(wdog_enable) |-> wdog_run_r)
    else $error("watchdog halted in stop mode");
  chk_halt_run: assert property (halt_mode_r && $past(halt_mode_r)
    |-> osc_run_r && sys_clk_en_r && periph_run_r && !cpu_run_r)
    else $error("halt mode clocks wrong");
  chk_pin_reset: assert property ((stop_mode_r && !reset_pin_n) ##1 (!reset_pin_n) [*3]
    |-> ##[0:4] sys_reset_r)
    else $error("reset pin low in stop gave no system reset");
  chk_glitch_drop: assert property (stop_mode_r && $fell(reset_pin_n) ##1 reset_pin_n
    |-> (!sys_reset_r) [*5])
    else $error("narrow reset pin pulse was not filtered");
  cov_stop: cover property (stop_mode_r ##1 sys_reset_r);
  cov_halt: cover property ($fell(halt_mode_r));
  cov_slverr: cover property (pready && pslverr);
endmodule // rcp_core_checker

bind rcp_core rcp_core_checker chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .reset_pin_n(reset_pin_n), .wdog_enable(wdog_enable),
  .wdog_ctl_we(wdog_ctl_we), .sys_reset_r(sys_reset_r), .stop_mode_r(stop_mode_r),
  .halt_mode_r(halt_mode_r), .osc_run_r(osc_run_r), .sys_clk_en_r(sys_clk_en_r),
  .cpu_run_r(cpu_run_r), .xtal_pins_gpio_r(xtal_pins_gpio_r), .wdog_run_r(wdog_run_r),
  .periph_run_r(periph_run_r), .comparator_disable(comparator_disable));

/* rcp_debug_watch.v */
// Watches the debug pin for break, framing error and collision, giving a registered reset for each cycle one is seen.
// Assumes the debug pin is synchronous and a bit time is a fixed count of clocks.
`include "rcp_map.vh"

module rcp_debug_watch (
  input wire clk_sys,
  input wire rstn,
  input wire debug_pin,
  input wire frame_stop_valid,
  input wire frame_stop_bit,
  input wire tx_active,
  input wire tx_bit,
  output reg dbg_reset_r
);

  reg [15:0] bit_cnt_r;
  reg [3:0] low_bits_r;
  wire bit_tick;
  wire brk;
  wire coll;

  assign bit_tick = (bit_cnt_r == `RCP_BIT_CYC - 16'h0001);
  assign brk = bit_tick && !debug_pin && (low_bits_r == 4'd`RCP_BREAK_BITS - 4'd1);
  // Driving high while line reads low means the host is driving too
  assign coll = tx_active && tx_bit && !debug_pin;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 16'h0000;
      low_bits_r <= 4'h0;
      dbg_reset_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_tick ? 16'h0000 : bit_cnt_r + 16'h0001;
      if (debug_pin) begin
        low_bits_r <= 4'h0;
      end else if (bit_tick && low_bits_r != 4'hf) begin
        low_bits_r <= low_bits_r + 4'h1;
      end
      dbg_reset_r <= brk | (frame_stop_valid & ~frame_stop_bit) | coll; // [RQ3] [RQ4]
    end
  end

endmodule // rcp_debug_watch

/* rcp_glitch_filter.v */
// Glitch filter for the external reset pin: passes a low only after it stands long enough.
// Assumes the pin is already synchronous to clk_sys.
`include "rcp_map.vh"

module rcp_glitch_filter (
  input wire clk_sys,
  input wire rstn,
  input wire pin_n,
  output reg low_seen_r
);

  reg [3:0] cnt_r;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
      low_seen_r <= 1'b0;
    end else if (pin_n) begin
      cnt_r <= 4'h0;
      low_seen_r <= 1'b0;
    end else if (cnt_r < 4'd`RCP_GLITCH_CYC - 4'd1) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      // Low stood on enough samples to be wider than the filter width
      low_seen_r <= 1'b1;
    end
  end

endmodule // rcp_glitch_filter

/* rcp_map.vh */
// Register offsets, field positions, reset values and timing counts for the reset cause block.
// Assumes a 100 MHz system clock and an APB slave with 32-bit data.
`ifndef RCP_MAP_VH
`define RCP_MAP_VH

// ************************************************************
// Register map
// ************************************************************
`define RCP_STATUS_ADDR 12'hff0
`define RCP_PGATE_ADDR 12'hf80
`define RCP_ADDR_W 12

// ************************************************************
// Fields
// ************************************************************
`define RCP_ST_POR 7
`define RCP_ST_STOP 6
`define RCP_ST_WDOG 5
`define RCP_ST_EXT 4
`define RCP_PG_BROWNOUT 4
`define RCP_PG_COMP 1
`define RCP_PG_RESET 8'h88
`define RCP_PG_WMASK 8'h12

// ************************************************************
// Timing
// ************************************************************
`define RCP_GLITCH_NS 12
`define RCP_CLK_NS 10
// Least width rounds up to whole cycles: 12 ns at 10 ns a cycle is two samples
`define RCP_GLITCH_CYC 2
`define RCP_BREAK_BITS 9
`define RCP_BIT_CYC 16'h0010

`endif
